// File: iopc_regs.svh
`ifndef IOPC_REGS_SVH
`define IOPC_REGS_SVH

// Register select code of the pin control register
`define IOPC_ADDR        6'h03
`define IOPC_RESET       24'h000000
// Field positions
`define IOPC_LEVEL_LSB   20
`define IOPC_ENABLE_LSB  16
`define IOPC_SWITCH_BIT  15
`define IOPC_ZERO_BIT    14
`define IOPC_MAG_B_LSB   11
`define IOPC_MAG_A_LSB   8
`define IOPC_PIN_B_LSB   4
`define IOPC_PIN_A_LSB   0

`endif

// File: iopc_pkg.sv
`default_nettype none
package iopc_pkg;

  // Excitation source magnitude
  typedef enum logic [2:0] {
    IOPC_MAG_OFF,
    IOPC_MAG_50UA,
    IOPC_MAG_100UA,
    IOPC_MAG_250UA,
    IOPC_MAG_500UA,
    IOPC_MAG_750UA,
    IOPC_MAG_1000UA,
    IOPC_MAG_0P1UA
  } iopc_mag_t;

endpackage
`default_nettype wire

// File: io_pin_control_register.sv
`timescale 1ns/1ps
`default_nettype none
`include "iopc_regs.svh"

module io_pin_control_register #(
  parameter int PINS = 4
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [5:0]        regAddr,
  input  wire logic              regWrite,
  input  wire logic [23:0]       regWrData,
  input  wire logic              regRead,
  output logic      [23:0]       regRdData,
  output logic                   regRdValid,
  input  wire logic              standbyMode,
  input  wire logic [PINS-1:0]   gpPinIn,
  output logic      [PINS-1:0]   gpPinOut,
  output logic      [PINS-1:0]   gpPinOe,
  output logic      [PINS-1:0]   analogInMode,
  output logic                   bridgeSwitchClose,
  output iopc_pkg::iopc_mag_t    exciteLevelA,
  output iopc_pkg::iopc_mag_t    exciteLevelB,
  output logic      [3:0]        excitePinA,
  output logic      [3:0]        excitePinB
);
  import iopc_pkg::*;

  logic [23:0]     ctrl_r;
  logic [PINS-1:0] pinMeta_r;
  logic [PINS-1:0] pinSync_r;
  logic [PINS-1:0] levelView;
  logic [23:0]     readView;
  logic            hit;
  logic [2:0]      magCodeA;
  logic [2:0]      magCodeB;

  assign hit = (regAddr == `IOPC_ADDR);

  // Control word, written whole; bit 14 is stored as given
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `IOPC_RESET;
    end else if (regWrite && hit) begin
      ctrl_r <= regWrData;
    end
  end

  // Two-stage synchroniser on the pin levels
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end else begin
      pinMeta_r <= gpPinIn;
      pinSync_r <= pinMeta_r;
    end
  end

  // Per pin drive, mode and readback
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      assign gpPinOe[gi]      = ctrl_r[`IOPC_ENABLE_LSB+gi];
      assign gpPinOut[gi]     = ctrl_r[`IOPC_LEVEL_LSB+gi];
      assign analogInMode[gi] = ~ctrl_r[`IOPC_ENABLE_LSB+gi];
      assign levelView[gi]    = ctrl_r[`IOPC_ENABLE_LSB+gi] ?
                                pinSync_r[gi] :
                                ctrl_r[`IOPC_LEVEL_LSB+gi];
    end
  endgenerate

  // Read image with live levels of enabled pins, stored bits of disabled pins, in the level field
  always_comb begin
    readView = ctrl_r;
    readView[`IOPC_LEVEL_LSB+PINS-1:`IOPC_LEVEL_LSB] = levelView;
  end

  // Registered read answer; other select codes read zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdData  <= '0;
      regRdValid <= 1'h0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        regRdData <= hit ? readView : 24'h000000;
      end
    end
  end

  // Switch follows its bit only; standby is not in its path
  assign bridgeSwitchClose = ctrl_r[`IOPC_SWITCH_BIT];

  // Magnitude decode; both sources share the eight-code table
  assign magCodeB     = ctrl_r[`IOPC_MAG_B_LSB+2:`IOPC_MAG_B_LSB];
  assign magCodeA     = ctrl_r[`IOPC_MAG_A_LSB+2:`IOPC_MAG_A_LSB];
  assign exciteLevelB = iopc_mag_t'(magCodeB);
  assign exciteLevelA = iopc_mag_t'(magCodeA);

  // Source routing to analog input n
  assign excitePinB = ctrl_r[`IOPC_PIN_B_LSB+3:`IOPC_PIN_B_LSB];
  assign excitePinA = ctrl_r[`IOPC_PIN_A_LSB+3:`IOPC_PIN_A_LSB];

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_wr_pin1;
    regWrite && hit && regWrData[`IOPC_ENABLE_LSB];
  endsequence

  property p_pin1_drive;
    s_wr_pin1 |=> gpPinOe[0] && gpPinOut[0] == $past(regWrData[20]);
  endproperty
  a_pin1_drive: assert property (p_pin1_drive)
    else $error("pin 1 not driven from level bit");

  property p_pin1_readback;
    regRead && hit && gpPinOe[0] && !regWrite
      |=> regRdValid && regRdData[20] == $past(pinSync_r[0]);
  endproperty
  a_pin1_readback: assert property (p_pin1_readback)
    else $error("pin 1 readback wrong");

  property p_mode;
    regWrite && hit |=> analogInMode == ~$past(regWrData[19:16]);
  endproperty
  a_mode: assert property (p_mode)
    else $error("pin mode does not follow enables");

  property p_switch;
    regWrite && hit |=> bridgeSwitchClose == $past(regWrData[15]);
  endproperty
  a_switch: assert property (p_switch)
    else $error("bridge switch wrong");

  property p_standby_hold;
    $changed(standbyMode) && !$past(regWrite && hit)
      |-> $stable(bridgeSwitchClose);
  endproperty
  a_standby_hold: assert property (p_standby_hold)
    else $error("switch moved at standby");

  property p_mag_b;
    regWrite && hit |=> exciteLevelB == iopc_mag_t'($past(regWrData[13:11]));
  endproperty
  a_mag_b: assert property (p_mag_b)
    else $error("second magnitude wrong");

  property p_mag_a;
    regWrite && hit && regWrData[10:8] == 3'h6 |=>
      exciteLevelA == IOPC_MAG_1000UA;
  endproperty
  a_mag_a: assert property (p_mag_a)
    else $error("first magnitude wrong");

  property p_pin4;
    regWrite && hit && regWrData[19] |=> gpPinOut[3] == $past(regWrData[23]);
  endproperty
  a_pin4: assert property (p_pin4)
    else $error("pin 4 not driven");

  property p_route;
    regWrite && hit |=> excitePinB == $past(regWrData[7:4])
      && excitePinA == $past(regWrData[3:0]);
  endproperty
  a_route: assert property (p_route)
    else $error("source routing wrong");

  property p_unmapped;
    regRead && !hit |=> regRdData == 24'h000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  // Control write seen at the register port
  sequence s_ctrl_write;
    regWrite && hit;
  endsequence

  property p_pins_drive;
    s_ctrl_write |=> gpPinOut[3:1] == $past(regWrData[23:21])
      && gpPinOe[3:1] == $past(regWrData[19:17]);
  endproperty
  a_pins_drive: assert property (p_pins_drive)
    else $error("pins 2 to 4 not driven from level bits");

  // Enabled pins read their synchronised level, disabled ones the stored bit
  property p_readback_all;
    regRead && hit && !regWrite |=> regRdValid && regRdData[23:20] ==
      $past((gpPinOe & pinSync_r) | (~gpPinOe & gpPinOut));
  endproperty
  a_readback_all: assert property (p_readback_all)
    else $error("level field readback wrong");

  // Read answer flag is a one-cycle echo of the read strobe
  property p_read_pulse;
    regRdValid == $past(regRead);
  endproperty
  a_read_pulse: assert property (p_read_pulse)
    else $error("read answer flag out of step");

  property p_mag_a750;
    regWrite && hit && regWrData[10:8] == 3'h5 |=>
      exciteLevelA == IOPC_MAG_750UA;
  endproperty
  a_mag_a750: assert property (p_mag_a750)
    else $error("first magnitude code 5 wrong");

  property p_mag_a01;
    regWrite && hit && regWrData[10:8] == 3'h7 |=>
      exciteLevelA == IOPC_MAG_0P1UA;
  endproperty
  a_mag_a01: assert property (p_mag_a01)
    else $error("first magnitude code 7 wrong");

endmodule // io_pin_control_register
`default_nettype wire

// File: iopc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module iopc_pin_model (
  input  wire logic [3:0] drive,
  input  wire logic [3:0] enable,
  input  wire logic [3:0] clash,
  output logic      [3:0] level
);
  // Undriven pins show the inverse so a stale value never passes
  assign level = drive ^ (~enable | clash);
endmodule // iopc_pin_model
`default_nettype wire

// File: io_pin_control_register_test.sv
`timescale 1ns/1ps
`default_nettype none
module io_pin_control_register_test;
  import iopc_pkg::*;
  logic        ref_clk = 0, rst = 1, regWrite = 0, regRead = 0;
  logic        standbyMode = 0, regRdValid, bridgeSwitchClose;
  logic [5:0]  regAddr = 6'h03;
  logic [23:0] regWrData = 24'h000000, regRdData;
  logic [3:0]  gpPinIn, gpPinOut, gpPinOe, analogInMode, clash = 4'h0;
  logic [3:0]  excitePinA, excitePinB;
  iopc_mag_t   exciteLevelA, exciteLevelB;
  // Magnitude expected for each field code
  iopc_mag_t   magTable [8] = '{IOPC_MAG_OFF, IOPC_MAG_50UA, IOPC_MAG_100UA,
    IOPC_MAG_250UA, IOPC_MAG_500UA, IOPC_MAG_750UA, IOPC_MAG_1000UA,
    IOPC_MAG_0P1UA};
  int          fail_count = 0, checks = 0;
  // Clock at 25 ns
  always #12.5 ref_clk = ~ref_clk;
  io_pin_control_register dut (.ref_clk(ref_clk), .rst(rst),
    .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData),
    .regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid),
    .standbyMode(standbyMode), .gpPinIn(gpPinIn), .gpPinOut(gpPinOut),
    .gpPinOe(gpPinOe), .analogInMode(analogInMode),
    .bridgeSwitchClose(bridgeSwitchClose), .exciteLevelA(exciteLevelA),
    .exciteLevelB(exciteLevelB), .excitePinA(excitePinA),
    .excitePinB(excitePinB));
  iopc_pin_model pins (.drive(gpPinOut), .enable(gpPinOe), .clash(clash),
    .level(gpPinIn));
  // Count one comparison
  task chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // One write strobe
  task wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge ref_clk) #1;
    regAddr = a;
    regWrData = d;
    regWrite = 1;
    @(posedge ref_clk) #1;
    regWrite = 0;
  endtask
  // One read strobe, answer compared a cycle later
  task rd(input logic [5:0] a, input logic [23:0] e);
    @(posedge ref_clk) #1;
    regAddr = a;
    regRead = 1;
    @(posedge ref_clk) #1;
    regRead = 0;
    chk(regRdValid === 1'h1 && regRdData === e, "read answer");
  endtask
  task finish_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog, far beyond the fifty or so cycles needed
  initial begin
    #20000;
    fail_count++;
    finish_test;
  end
  // Main sequence; every write except the foreign 24'hFFFFFF keeps bit 14 low
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rst = 0;
    chk(gpPinOe === 4'h0 && analogInMode === 4'hF, "reset mode");
    rd(6'h03, 24'h000000);
    for (int i = 0; i < 8; i++) begin
      wr(6'h03, {10'h000, i[2:0], 3'(7 - i), 4'(i), 4'(15 - i)});
      chk(exciteLevelB === magTable[i], "magnitude b");
      chk(exciteLevelA === magTable[7 - i], "magnitude a");
      chk(excitePinB === 4'(i), "route b");
      chk(excitePinA === 4'(15 - i), "route a");
    end
    wr(6'h03, 24'hAF8000);
    chk(gpPinOut === 4'hA && gpPinOe === 4'hF, "pin drive");
    chk(analogInMode === 4'h0, "pin mode");
    chk(bridgeSwitchClose === 1'h1, "switch closed");
    clash = 4'h5;
    // Standby moves one idle cycle after the write so its check is reached
    @(posedge ref_clk) #1;
    standbyMode = 1;
    repeat (4) @(posedge ref_clk);
    #1 chk(bridgeSwitchClose === 1'h1, "switch in standby");
    rd(6'h03, 24'hFF8000);
    wr(6'h03, 24'h530000);
    chk(analogInMode === 4'hC, "pin mode");
    chk(bridgeSwitchClose === 1'h0, "switch open");
    repeat (4) @(posedge ref_clk);
    rd(6'h03, 24'h430000);
    standbyMode = 0;
    wr(6'h02, 24'hFFFFFF);
    chk(gpPinOe === 4'h3, "foreign write");
    chk(bridgeSwitchClose === 1'h0, "switch leaving standby");
    rd(6'h02, 24'h000000);
    // Second reset in mid-run returns every control to idle
    @(posedge ref_clk) #1 rst = 1;
    @(posedge ref_clk) #1 rst = 0;
    chk(gpPinOe === 4'h0 && gpPinOut === 4'h0, "reset pins");
    chk(bridgeSwitchClose === 1'h0, "reset switch");
    chk(exciteLevelA === IOPC_MAG_OFF, "reset magnitude a");
    chk(exciteLevelB === IOPC_MAG_OFF, "reset magnitude b");
    chk(excitePinA === 4'h0 && excitePinB === 4'h0, "reset route");
    rd(6'h03, 24'h000000);
    finish_test;
  end
endmodule // io_pin_control_register_test
`default_nettype wire
